// ### logic/fft_scale_defs.svh
// Purpose: Constants for the FFT block-floating-point scaling stage
// Assumes: Q1.15 operands, 17-bit adder results, 35-bit accumulator
// Notes:   Definitions only; included by bare name
// ====================================================================
// Overview of operation
// - Operands and coefficients are signed two's-complement fractions.
// - Accumulation stays at 35 bits; a rounded 16-bit value goes out.
// - Halving option takes the accumulator slice weighted 2^1..2^-14.
// - Full-range option limits the coefficient to -1+1 LSB and takes 2^0..2^-15.
// - Either adder output at or above 0.5 latches a matching shift code.
// - The code latched in one stage right-shifts all operands of the next.
// - The difference output has its own duplicate overflow detection.
// - Without a shifter, only sign and top fifteen fraction bits pass.
`ifndef FFT_SCALE_DEFS_SVH
`define FFT_SCALE_DEFS_SVH

// ====================================================================
// Register map
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define CTRL_FULL_BIT 0
`define CTRL_ROUND_BIT 1
`define CTRL_SCALE_BIT 2
`define CTRL_CLR_BIT 3
`define CTRL_FULL_RST 1'b1
`define CTRL_ROUND_RST 1'b1
`define CTRL_SCALE_RST 1'b1
`define STAT_ACTIVE_LSB 0
`define STAT_PEND_LSB 4
`define STAT_COUNT_LSB 8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ====================================================================
// Datapath constants
`define HALVED_MSB 31
`define HALVED_LSB 16
`define FULL_MSB 30
`define FULL_LSB 15
`define HALVED_RND 36'h000008000
`define FULL_RND 36'h000004000
`define COEF_MOST_NEG 16'h8000
`define COEF_LIMIT 16'h8001
`define HALF_Q 17'h04000
`define ONE_Q 17'h08000

`endif

// ### logic/fft_scale_pkg.sv
// Purpose: Types shared by the scaling stage
// Assumes: Constants live in fft_scale_defs.svh
// Notes:   No imports; users write fft_scale_pkg::name
package fft_scale_pkg;

  // ==================================================================
  // Types
  typedef logic [1:0] shift_code_t;

  typedef struct packed {
    logic [16:0] sum;
    logic [16:0] diff;
  } adder_pair_t;

  typedef struct packed {
    logic scale_en;
    logic round_en;
    logic full_range;
  } ctrl_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_EXEC = 2'b01,
    WR_RESP = 2'b11
  } wr_state_t;

endpackage

// ### logic/operand_barrel_shift.sv
// Purpose: Registered arithmetic right shift of one operand
// Assumes: Code is stable for a whole FFT stage
// Notes:   One cycle latency, valid follows data
`timescale 1ns/1ns
module operand_barrel_shift #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  input wire fft_scale_pkg::shift_code_t code_i,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o
);

  // ==================================================================
  // Shift stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= in_valid_i;
    end
  end

  // Sign is replicated so a scaled fraction keeps its sign
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_data_o <= '0;
    end else if (in_valid_i) begin
      out_data_o <= W'($signed(in_data_i) >>> code_i);
    end
  end

endmodule // operand_barrel_shift

// ### logic/fft_block_float_scaling.sv
// Purpose: Overflow, underflow and precision stage of an FFT butterfly
// Assumes: All datapath inputs come from logic on CLOCK_I
// Notes:   Registers over AXI4-Lite; one write and one read at a time
`timescale 1ns/1ns
`include "fft_scale_defs.svh"
module fft_block_float_scaling #(
  parameter int ADDR_W = 8,
  parameter bit SHIFTER_FITTED = 1'b1
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [34:0] MAC_ACC_I,
  input wire logic MAC_VALID_I,
  output logic [15:0] MAC_OPERAND_O,
  output logic MAC_OPERAND_VALID_O,
  input wire logic [15:0] COEF_I,
  input wire logic COEF_VALID_I,
  output logic [15:0] COEF_O,
  output logic COEF_VALID_O,
  input wire fft_scale_pkg::adder_pair_t ADDER_PAIR_I,
  input wire logic ADD_VALID_I,
  input wire logic STAGE_START_I,
  input wire logic FIRST_STAGE_I,
  input wire logic [15:0] OPERAND_I,
  input wire logic OPERAND_VALID_I,
  output logic [15:0] SCALED_OPERAND_O,
  output logic SCALED_VALID_O,
  output fft_scale_pkg::shift_code_t SHIFT_CODE_O,
  output logic ROUND_CONTROL_O
);

  // ==================================================================
  // Functions
  function automatic fft_scale_pkg::shift_code_t shift_need(
    input logic [16:0] v
  );
    logic [16:0] mag;
    mag = v[16] ? 17'(~v + 17'h00001) : v;
    if (mag >= `ONE_Q) begin
      return 2'h2;
    end else if (mag >= `HALF_Q) begin
      return 2'h1;
    end else begin
      return 2'h0;
    end
  endfunction

  function automatic fft_scale_pkg::shift_code_t code_max(
    input fft_scale_pkg::shift_code_t a,
    input fft_scale_pkg::shift_code_t b
  );
    return (a > b) ? a : b;
  endfunction

  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    return a[7:0] == `REG_CTRL_OFS;
  endfunction

  function automatic logic is_status(input logic [ADDR_W-1:0] a);
    return a[7:0] == `REG_STATUS_OFS;
  endfunction

  // ==================================================================
  // Declarations
  fft_scale_pkg::ctrl_t ctrl_ff;
  fft_scale_pkg::wr_state_t wr_state_ff;
  fft_scale_pkg::shift_code_t pend_code_ff;
  fft_scale_pkg::shift_code_t active_code_ff;
  fft_scale_pkg::shift_code_t sum_need;
  fft_scale_pkg::shift_code_t diff_need;
  fft_scale_pkg::shift_code_t nxt_pend;
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [7:0] stage_count_ff;
  logic code_clr;
  logic use_full;
  logic [35:0] round_add;
  logic [35:0] rnd_sum;
  logic [15:0] mac_slice;
  logic aw_hs;
  logic w_hs;

  // ==================================================================
  // AXI4-Lite write channel
  assign aw_hs = AWVALID_I && AWREADY_O;
  assign w_hs = WVALID_I && WREADY_O;
  assign AWREADY_O = (wr_state_ff == fft_scale_pkg::WR_COLLECT) &&
                     !aw_held_ff;
  assign WREADY_O = (wr_state_ff == fft_scale_pkg::WR_COLLECT) &&
                    !w_held_ff;
  assign BVALID_O = (wr_state_ff == fft_scale_pkg::WR_RESP);

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wr_state_ff <= fft_scale_pkg::WR_COLLECT;
    end else begin
      case (wr_state_ff)
        fft_scale_pkg::WR_COLLECT: begin
          if ((aw_held_ff || aw_hs) && (w_held_ff || w_hs)) begin
            wr_state_ff <= fft_scale_pkg::WR_EXEC;
          end
        end
        fft_scale_pkg::WR_EXEC: begin
          wr_state_ff <= fft_scale_pkg::WR_RESP;
        end
        default: begin
          if (BREADY_I) begin
            wr_state_ff <= fft_scale_pkg::WR_COLLECT;
          end
        end
      endcase
    end
  end

  // Address and data may arrive in either order
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (wr_state_ff == fft_scale_pkg::WR_EXEC) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= AWADDR_I;
      end
      if (w_hs) begin
        w_held_ff <= 1'b1;
        w_data_ff <= WDATA_I;
        w_strb_ff <= WSTRB_I;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      BRESP_O <= `RESP_OKAY;
    end else if (wr_state_ff == fft_scale_pkg::WR_EXEC) begin
      if (is_ctrl(aw_addr_ff) || is_status(aw_addr_ff)) begin
        BRESP_O <= `RESP_OKAY;
      end else begin
        BRESP_O <= `RESP_SLVERR;
      end
    end
  end

  // Only byte lane 0 holds control bits
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_ff.full_range <= `CTRL_FULL_RST;
      ctrl_ff.round_en <= `CTRL_ROUND_RST;
      ctrl_ff.scale_en <= `CTRL_SCALE_RST;
    end else if (wr_state_ff == fft_scale_pkg::WR_EXEC &&
                 is_ctrl(aw_addr_ff) && w_strb_ff[0]) begin
      ctrl_ff.full_range <= w_data_ff[`CTRL_FULL_BIT];
      ctrl_ff.round_en <= w_data_ff[`CTRL_ROUND_BIT];
      ctrl_ff.scale_en <= w_data_ff[`CTRL_SCALE_BIT];
    end
  end

  assign code_clr = (wr_state_ff == fft_scale_pkg::WR_EXEC) &&
                    is_ctrl(aw_addr_ff) && w_strb_ff[0] &&
                    w_data_ff[`CTRL_CLR_BIT];

  // ==================================================================
  // AXI4-Lite read channel
  assign ARREADY_O = !RVALID_O;

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= `RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RRESP_O <= `RESP_OKAY;
      RDATA_O <= '0;
      if (is_ctrl(ARADDR_I)) begin
        RDATA_O[`CTRL_FULL_BIT] <= ctrl_ff.full_range;
        RDATA_O[`CTRL_ROUND_BIT] <= ctrl_ff.round_en;
        RDATA_O[`CTRL_SCALE_BIT] <= ctrl_ff.scale_en;
      end else if (is_status(ARADDR_I)) begin
        RDATA_O[`STAT_ACTIVE_LSB +: 2] <= active_code_ff;
        RDATA_O[`STAT_PEND_LSB +: 2] <= pend_code_ff;
        RDATA_O[`STAT_COUNT_LSB +: 8] <= stage_count_ff;
      end else begin
        RRESP_O <= `RESP_SLVERR;
      end
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  // ==================================================================
  // Multiplier-accumulator slice select and rounding
  // Halving costs one bit of precision but is safe for any coefficient
  assign use_full = ctrl_ff.full_range && SHIFTER_FITTED;
  assign ROUND_CONTROL_O = ctrl_ff.round_en;

  always_comb begin
    round_add = '0;
    if (ctrl_ff.round_en) begin
      round_add = use_full ? `FULL_RND : `HALVED_RND;
    end
    rnd_sum = 36'({MAC_ACC_I[34], MAC_ACC_I} + round_add);
    if (use_full) begin
      mac_slice = rnd_sum[`FULL_MSB:`FULL_LSB];
    end else begin
      mac_slice = rnd_sum[`HALVED_MSB:`HALVED_LSB];
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MAC_OPERAND_VALID_O <= 1'b0;
      MAC_OPERAND_O <= '0;
    end else begin
      MAC_OPERAND_VALID_O <= MAC_VALID_I;
      if (MAC_VALID_I) begin
        MAC_OPERAND_O <= mac_slice;
      end
    end
  end

  // Full-range mode relies on the product staying below 1.0
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      COEF_VALID_O <= 1'b0;
      COEF_O <= '0;
    end else begin
      COEF_VALID_O <= COEF_VALID_I;
      if (COEF_VALID_I) begin
        if (use_full && COEF_I == `COEF_MOST_NEG) begin
          COEF_O <= `COEF_LIMIT;
        end else begin
          COEF_O <= COEF_I;
        end
      end
    end
  end

  // ==================================================================
  // Shift encoder
  assign sum_need = shift_need(ADDER_PAIR_I.sum);
  assign diff_need = shift_need(ADDER_PAIR_I.diff);
  assign nxt_pend = ADD_VALID_I ? code_max(sum_need, diff_need) : 2'h0;

  // Same-cycle adder results count toward the new stage
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pend_code_ff <= '0;
    end else if (code_clr) begin
      pend_code_ff <= '0;
    end else if (FIRST_STAGE_I || STAGE_START_I) begin
      pend_code_ff <= nxt_pend;
    end else begin
      pend_code_ff <= code_max(pend_code_ff, nxt_pend);
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      active_code_ff <= '0;
    end else if (FIRST_STAGE_I || code_clr) begin
      active_code_ff <= '0;
    end else if (STAGE_START_I) begin
      active_code_ff <= ctrl_ff.scale_en ? pend_code_ff : 2'h0;
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      stage_count_ff <= '0;
    end else if (FIRST_STAGE_I) begin
      stage_count_ff <= 8'h01;
    end else if (STAGE_START_I) begin
      stage_count_ff <= 8'(stage_count_ff + 8'h01);
    end
  end

  assign SHIFT_CODE_O = active_code_ff;

  // ==================================================================
  // Operand scaling for the next stage
  operand_barrel_shift #(
    .W(16)
  ) u_shift (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(OPERAND_VALID_I),
    .in_data_i(OPERAND_I),
    .code_i(SHIFTER_FITTED ? active_code_ff : 2'h0),
    .out_valid_o(SCALED_VALID_O),
    .out_data_o(SCALED_OPERAND_O)
  );

  // ==================================================================
  // Assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_quiet;
    !STAGE_START_I && !FIRST_STAGE_I && !code_clr;
  endsequence

  sequence s_stage_edge;
    STAGE_START_I && !FIRST_STAGE_I && !code_clr && ctrl_ff.scale_en;
  endsequence

  property p_sign_kept;
    OPERAND_VALID_I |=> SCALED_OPERAND_O[15] == $past(OPERAND_I[15]);
  endproperty
  a_sign_kept: assert property (p_sign_kept)
    else $error("scaled operand lost its sign");

  property p_mac_timing;
    MAC_VALID_I && !ctrl_ff.round_en && !use_full |=>
      MAC_OPERAND_VALID_O && MAC_OPERAND_O == $past(MAC_ACC_I[31:16]);
  endproperty
  a_mac_timing: assert property (p_mac_timing)
    else $error("unrounded operand wrong or late");

  property p_halved;
    MAC_VALID_I && ctrl_ff.round_en && !use_full |=>
      MAC_OPERAND_O == $past(16'((MAC_ACC_I + 35'h8000) >> 16));
  endproperty
  a_halved: assert property (p_halved)
    else $error("halved slice not rounded correctly");

  property p_coef_limit;
    COEF_VALID_I && use_full && COEF_I == 16'h8000 |=>
      COEF_O == 16'h8001;
  endproperty
  a_coef_limit: assert property (p_coef_limit)
    else $error("most negative coefficient not limited");

  property p_sum_detect;
    s_quiet ##0 ADD_VALID_I && ADDER_PAIR_I.sum[16:14] == 3'b001 |=>
      pend_code_ff >= 2'h1;
  endproperty
  a_sum_detect: assert property (p_sum_detect)
    else $error("sum at or above one half not latched");

  property p_next_stage;
    s_stage_edge |=> active_code_ff == $past(pend_code_ff)
      ##1 (STAGE_START_I || FIRST_STAGE_I || code_clr ||
           $stable(active_code_ff));
  endproperty
  a_next_stage: assert property (p_next_stage)
    else $error("stage code not carried to next stage");

  property p_diff_detect;
    s_quiet ##0 ADD_VALID_I && ADDER_PAIR_I.diff == 17'h18000 |=>
      pend_code_ff == 2'h2;
  endproperty
  a_diff_detect: assert property (p_diff_detect)
    else $error("difference underflow not latched");

  property p_no_shifter;
    !SHIFTER_FITTED && MAC_VALID_I && !ctrl_ff.round_en |=>
      MAC_OPERAND_O == {$past(MAC_ACC_I[31]), $past(MAC_ACC_I[30:16])};
  endproperty
  a_no_shifter: assert property (p_no_shifter)
    else $error("wrong slice without shifter");

  property p_first_clear;
    FIRST_STAGE_I |=> active_code_ff == 2'h0;
  endproperty
  a_first_clear: assert property (p_first_clear)
    else $error("code not cleared at first stage");

  property p_hold;
    !STAGE_START_I && !FIRST_STAGE_I && !code_clr |=>
      $stable(active_code_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("code changed inside a stage");

endmodule // fft_block_float_scaling

// ### test/bfly_adder_model.sv
// Purpose: Behavioural model of the two butterfly adders
// Assumes: Operands are two's-complement Q1.15 fractions
// Notes:   Idle result lines toggle so stale data never looks valid
`timescale 1ns/1ns
module bfly_adder_model (
  input wire logic clk_i,
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  input wire logic go_i,
  output fft_scale_pkg::adder_pair_t pair_o,
  output logic valid_o
);
  // ==================================================================
  // Adders
  initial pair_o = '0;
  initial valid_o = 1'b0;
  always @(posedge clk_i) begin
    valid_o <= go_i;
    if (go_i) begin
      pair_o.sum <= {a_i[15], a_i} + {b_i[15], b_i};
      pair_o.diff <= {a_i[15], a_i} - {b_i[15], b_i};
    end else begin
      // Released lines invert every idle cycle, so the last result returns every second cycle
      pair_o <= ~pair_o;
    end
  end
endmodule // bfly_adder_model

// ### test/tb_fft_block_float_scaling.sv
// Purpose: Self-checking bench for the FFT scaling stage
// Assumes: Partner adders feed the adder pair port
// Notes:   Drivers queue expected values; a monitor compares them
`timescale 1ns/1ns
module tb_fft_block_float_scaling;
  // ==================================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0;
  logic [34:0] acc = '0;
  logic [15:0] coef = '0, opnd = '0, pa = '0, pb = '0;
  logic macv = 0, coefv = 0, opv = 0, go = 0, stg = 0, fst = 0;
  logic [1:0] bresp, rresp, code;
  logic [31:0] rdata;
  logic [15:0] maco, coefo, sclo;
  logic awrdy, wrdy, bv, arrdy, rv, macov, coefov, sclv, rndc, addv;
  fft_scale_pkg::adder_pair_t pair;
  int mismatches = 0;
  int samples_checked = 0;
  logic [15:0] q_mac[$], q_coef[$], q_scl[$];
  logic [33:0] q_rd[$];
  logic [1:0] q_b[$];

  always #10 clk = ~clk;

  // ==================================================================
  // Design and partner
  fft_block_float_scaling #(.ADDR_W(8), .SHIFTER_FITTED(1'b1)) dut_u (
    .CLOCK_I(clk), .SYS_RST_I(rst),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awrdy),
    .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wrdy),
    .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arrdy),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rready),
    .MAC_ACC_I(acc), .MAC_VALID_I(macv),
    .MAC_OPERAND_O(maco), .MAC_OPERAND_VALID_O(macov),
    .COEF_I(coef), .COEF_VALID_I(coefv),
    .COEF_O(coefo), .COEF_VALID_O(coefov),
    .ADDER_PAIR_I(pair), .ADD_VALID_I(addv),
    .STAGE_START_I(stg), .FIRST_STAGE_I(fst),
    .OPERAND_I(opnd), .OPERAND_VALID_I(opv),
    .SCALED_OPERAND_O(sclo), .SCALED_VALID_O(sclv),
    .SHIFT_CODE_O(code), .ROUND_CONTROL_O(rndc)
  );
  bfly_adder_model adders_u (
    .clk_i(clk), .a_i(pa), .b_i(pb), .go_i(go),
    .pair_o(pair), .valid_o(addv)
  );

  // ==================================================================
  // Checking
  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Old values are read at the edge, so a one-cycle valid is seen once
  always @(posedge clk) begin
    if (macov === 1'b1) chk("mac operand", q_mac.pop_front(), maco);
    if (coefov === 1'b1) chk("coef", q_coef.pop_front(), coefo);
    if (sclv === 1'b1) chk("scaled", q_scl.pop_front(), sclo);
    if (rv === 1'b1 && rready) chk("read", q_rd.pop_front(), {rresp, rdata});
    if (bv === 1'b1 && bready) chk("bresp", q_b.pop_front(), bresp);
  end

  // ==================================================================
  // Bus and stream drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    q_b.push_back(er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!b) begin
      @(posedge clk);
      if (aw && w && bv === 1'b1) begin
        b = 1;
        bready <= 0;
      end
      if (!aw && awrdy === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wrdy === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    bit ar, r;
    ar = 0;
    r = 0;
    q_rd.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!r) begin
      @(posedge clk);
      if (ar && rv === 1'b1) begin
        r = 1;
        rready <= 0;
      end
      if (!ar && arrdy === 1'b1) begin
        ar = 1;
        arvalid <= 0;
      end
    end
  endtask

  task automatic macs(input bit full, input bit rnd);
    logic [34:0] a;
    logic [15:0] c;
    logic [35:0] s;
    for (int i = 0; i < 8; i++) begin
      a = (i == 1) ? 35'h000007fff : 35'({$urandom, $urandom});
      c = (i == 0) ? 16'h8000 : 16'($urandom);
      s = {a[34], a} + (rnd ? (full ? 36'h4000 : 36'h8000) : 36'h0);
      @(posedge clk);
      acc <= a;
      coef <= c;
      macv <= 1;
      coefv <= 1;
      q_mac.push_back(full ? s[30:15] : s[31:16]);
      q_coef.push_back((full && c == 16'h8000) ? 16'h8001 : c);
    end
    @(posedge clk);
    macv <= 0;
    coefv <= 0;
  endtask

  task automatic add(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    pa <= a;
    pb <= b;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (2) @(posedge clk);
  endtask

  task automatic stage(input bit first, input logic [1:0] ec);
    @(posedge clk);
    stg <= !first;
    fst <= first;
    @(posedge clk);
    stg <= 0;
    fst <= 0;
    #1 chk("shift code", ec, code);
  endtask

  task automatic ops(input int sh);
    logic [15:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      @(posedge clk);
      opnd <= v;
      opv <= 1;
      q_scl.push_back($signed(v) >>> sh);
    end
    @(posedge clk);
    opv <= 0;
  endtask

  // ==================================================================
  // Scenarios
  initial begin
    void'($urandom(26102));
    repeat (12) @(posedge clk);
    rst <= 0;
    rd(8'h00, {2'b00, 32'h7});
    rd(8'h04, 34'h0);
    rd(8'h08, {2'b10, 32'h0});
    wr(8'h0c, 32'h0, 2'b10);
    wr(8'h04, 32'hffff, 2'b00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'(4 | m), 2'b00);
      #1 chk("round control", m[1], rndc);
      macs(m[0], m[1]);
    end
    stage(1, 2'd0);
    add(16'h1000, 16'hd000);
    #1 chk("held code", 2'd0, code);
    stage(0, 2'd1);
    ops(1);
    add(16'hc000, 16'hc000);
    stage(0, 2'd2);
    ops(2);
    stage(0, 2'd0);
    ops(0);
    rd(8'h04, {2'b00, 32'h400});
    add(16'h5000, 16'h4000);
    stage(0, 2'd2);
    wr(8'h00, 32'hf, 2'b00);
    #1 chk("cleared code", 2'd0, code);
    repeat (4) @(posedge clk);
    stop_test;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule // tb_fft_block_float_scaling
